// [rtl/lane_ctrl_regs.sv]
// Lane direct control registers behind the two-wire management port
`timescale 1ns/1ns
module lane_ctrl_regs (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  input wire logic [lane_ctrl_pkg::LANES-1:0] tx_signal_valid,
  input wire logic [lane_ctrl_pkg::LANES-1:0] rx_signal_valid,
  input wire logic [lane_ctrl_pkg::LANES-1:0] rx_path_ready,
  output logic [lane_ctrl_pkg::LANES-1:0] tx_input_polarity_invert,
  output logic [lane_ctrl_pkg::LANES-1:0] tx_output_off,
  output logic [lane_ctrl_pkg::LANES-1:0] tx_auto_mute_off,
  output logic [lane_ctrl_pkg::LANES-1:0] tx_forced_mute,
  output logic [lane_ctrl_pkg::LANES-1:0] tx_equalizer_hold,
  output logic [lane_ctrl_pkg::LANES-1:0] tx_eq_save_buf1,
  output logic [lane_ctrl_pkg::LANES-1:0] tx_eq_save_buf2,
  output logic [lane_ctrl_pkg::LANES-1:0] tx_mute,
  output logic [lane_ctrl_pkg::LANES-1:0] rx_output_polarity_invert,
  output logic [lane_ctrl_pkg::LANES-1:0] rx_output_off,
  output logic [lane_ctrl_pkg::LANES-1:0] rx_auto_mute_off,
  output logic [lane_ctrl_pkg::LANES-1:0] rx_mute
);
  import lane_ctrl_pkg::*;

  typedef enum logic [3:0] {
    S_IDLE,
    S_ADDR,
    S_ADDR_ACK,
    S_OFFS,
    S_OFFS_ACK,
    S_WDATA,
    S_WDATA_ACK,
    S_RDATA,
    S_RACK
  } link_st_t;

  typedef struct packed {
    link_st_t st;
    logic [3:0] cnt;
    logic [7:0] shift;
    logic [7:0] rbuf;
    logic [7:0] offset;
    logic rw;
    logic sda_low;
    logic armed;
    logic [LANES-1:0] tx_pol;
    logic [LANES-1:0] tx_off;
    logic [LANES-1:0] tx_auto_off;
    logic [LANES-1:0] tx_force;
    logic [LANES-1:0] tx_hold;
    logic [LANES-1:0] rx_pol;
    logic [LANES-1:0] rx_off;
    logic [LANES-1:0] rx_auto_off;
    logic [LANES-1:0] save1;
    logic [LANES-1:0] save2;
    logic [LANES-1:0] tx_mute;
    logic [LANES-1:0] rx_mute;
  } regs_t;

  localparam regs_t REGS_RST = '{
    st: S_IDLE,
    tx_pol: RST_CTRL,
    tx_off: RST_CTRL,
    tx_auto_off: RST_CTRL,
    tx_force: RST_CTRL,
    tx_hold: RST_CTRL,
    rx_pol: RST_CTRL,
    rx_off: RST_CTRL,
    rx_auto_off: RST_CTRL,
    default: '0
  };

  regs_t s_q;
  regs_t s_d;
  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;
  logic sda_level;
  logic wr_stb;
  logic [7:0] next_off;
  logic [7:0] rd_first;
  logic [7:0] rd_next;

  twi_edges u_edges (
    .mclk(mclk),
    .rstn(rstn),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .scl_rise(scl_rise),
    .scl_fall(scl_fall),
    .start_seen(start_seen),
    .stop_seen(stop_seen),
    .sda_level(sda_level)
  );

  // Store bytes are write-only; they read back as zero
  function automatic logic [7:0] read_byte(input regs_t s, input logic [7:0] off);
    logic [7:0] v;
    v = RD_NONE;
    case (off)
      OFF_TX_POL: v = s.tx_pol;
      OFF_TX_OFF: v = s.tx_off;
      OFF_TX_AUTO: v = s.tx_auto_off;
      OFF_TX_FORCE: v = s.tx_force;
      OFF_TX_HOLD: v = s.tx_hold;
      OFF_RX_POL: v = s.rx_pol;
      OFF_RX_OFF: v = s.rx_off;
      OFF_RX_AUTO: v = s.rx_auto_off;
      default: v = RD_NONE; // [R16] [R17]
    endcase
    return v;
  endfunction

  // Lanes of one store byte whose two-bit field holds the given code
  function automatic logic [SAVE_LANES-1:0] save_hits(input logic [7:0] b,
                                                      input logic [1:0] code);
    logic [SAVE_LANES-1:0] h;
    h = '0;
    for (int i = 0; i < SAVE_LANES; i++)
      h[i] = (b[2*i+:2] == code);
    return h;
  endfunction

  assign wr_stb = (s_q.st == S_WDATA) && scl_fall && (s_q.cnt == BYTE_BITS);
  assign next_off = s_q.offset + 8'h01;
  assign rd_first = read_byte(s_q, s_q.offset);
  assign rd_next = read_byte(s_q, next_off);

  always_comb
  begin
    s_d = s_q;
    s_d.armed = 1'h1;
    s_d.save1 = '0;
    s_d.save2 = '0;
    // Disable wins: squelch is masked while a Tx output is off
    s_d.tx_mute = ~s_q.tx_off & (s_q.tx_force | (~s_q.tx_auto_off & ~tx_signal_valid)); // [R7] [R8] [R9]
    // Rx muting has no host force; only the automatic controller acts
    s_d.rx_mute = ~s_q.rx_auto_off & ~(rx_signal_valid & rx_path_ready); // [R1] [R2] [R3] [R4]
    if (wr_stb)
    begin
      case (s_q.offset)
        OFF_TX_POL: s_d.tx_pol = s_q.shift; // [R6]
        OFF_TX_OFF: s_d.tx_off = s_q.shift; // [R7]
        OFF_TX_AUTO: s_d.tx_auto_off = s_q.shift; // [R8]
        OFF_TX_FORCE: s_d.tx_force = s_q.shift; // [R9]
        OFF_TX_HOLD: s_d.tx_hold = s_q.shift; // [R10]
        OFF_TX_SAVE_LO:
        begin
          s_d.save1[SAVE_LANES-1:0] = save_hits(s_q.shift, EQ_SAVE_BUF1); // [R11] [R17]
          s_d.save2[SAVE_LANES-1:0] = save_hits(s_q.shift, EQ_SAVE_BUF2); // [R11] [R17]
        end
        OFF_TX_SAVE_HI:
        begin
          s_d.save1[LANES-1:SAVE_LANES] = save_hits(s_q.shift, EQ_SAVE_BUF1); // [R11]
          s_d.save2[LANES-1:SAVE_LANES] = save_hits(s_q.shift, EQ_SAVE_BUF2); // [R11]
        end
        OFF_RX_POL: s_d.rx_pol = s_q.shift; // [R12]
        OFF_RX_OFF: s_d.rx_off = s_q.shift; // [R13] [R14]
        OFF_RX_AUTO: s_d.rx_auto_off = s_q.shift; // [R3] [R15]
        default: ; // [R16]
      endcase
    end
    // A start or stop aborts any transfer in flight
    if (start_seen)
    begin
      s_d.st = S_ADDR;
      s_d.cnt = '0;
      s_d.sda_low = 1'h0;
    end
    else if (stop_seen)
    begin
      s_d.st = S_IDLE;
      s_d.sda_low = 1'h0;
    end
    else
    begin
      unique case (s_q.st)
        S_IDLE: ;
        S_ADDR, S_OFFS, S_WDATA:
        begin
          if (scl_rise && s_q.cnt != BYTE_BITS)
          begin
            s_d.shift = {s_q.shift[6:0], sda_level};
            s_d.cnt = s_q.cnt + 4'h1;
          end
          else if (scl_fall && s_q.cnt == BYTE_BITS)
          begin
            s_d.sda_low = 1'h1;
            s_d.st = (s_q.st == S_OFFS) ? S_OFFS_ACK : S_WDATA_ACK;
            if (s_q.st == S_ADDR)
            begin
              s_d.rw = s_q.shift[0];
              s_d.st = S_ADDR_ACK;
              // Other addresses get no acknowledge
              if (s_q.shift[7:1] != DEV_ADDR)
              begin
                s_d.sda_low = 1'h0;
                s_d.st = S_IDLE;
              end
            end
          end
        end
        S_ADDR_ACK:
        begin
          if (scl_fall)
          begin
            s_d.cnt = '0;
            if (s_q.rw == RW_READ)
            begin
              s_d.rbuf = rd_first;
              s_d.sda_low = ~rd_first[7];
              s_d.st = S_RDATA;
            end
            else
            begin
              s_d.sda_low = 1'h0;
              s_d.st = S_OFFS;
            end
          end
        end
        S_OFFS_ACK:
        begin
          if (scl_fall)
          begin
            s_d.offset = s_q.shift;
            s_d.sda_low = 1'h0;
            s_d.cnt = '0;
            s_d.st = S_WDATA;
          end
        end
        S_WDATA_ACK:
        begin
          if (scl_fall)
          begin
            s_d.offset = next_off;
            s_d.sda_low = 1'h0;
            s_d.cnt = '0;
            s_d.st = S_WDATA;
          end
        end
        S_RDATA:
        begin
          if (scl_fall)
          begin
            s_d.cnt = s_q.cnt + 4'h1;
            if (s_q.cnt == LAST_BIT)
            begin
              s_d.sda_low = 1'h0;
              s_d.st = S_RACK;
            end
            else
            begin
              s_d.rbuf = {s_q.rbuf[6:0], 1'h0};
              s_d.sda_low = ~s_q.rbuf[6];
            end
          end
        end
        S_RACK:
        begin
          // A high acknowledge bit ends the read
          if (scl_rise && sda_level)
            s_d.st = S_IDLE;
          else if (scl_fall)
          begin
            s_d.offset = next_off;
            s_d.rbuf = rd_next;
            s_d.sda_low = ~rd_next[7];
            s_d.cnt = '0;
            s_d.st = S_RDATA;
          end
        end
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      s_q <= REGS_RST;
    else
      s_q <= s_d;
  end

  // Open drain: only ever pulls low
  assign sda_out = 1'h0;
  assign sda_oe_n = ~s_q.sda_low;
  assign tx_input_polarity_invert = s_q.tx_pol; // [R6]
  assign tx_output_off = s_q.tx_off; // [R7]
  assign tx_auto_mute_off = s_q.tx_auto_off;
  assign tx_forced_mute = s_q.tx_force;
  assign tx_equalizer_hold = s_q.tx_hold; // [R10]
  assign tx_eq_save_buf1 = s_q.save1;
  assign tx_eq_save_buf2 = s_q.save2;
  assign tx_mute = s_q.tx_mute;
  assign rx_output_polarity_invert = s_q.rx_pol; // [R12]
  assign rx_output_off = s_q.rx_off; // [R13]
  assign rx_auto_mute_off = s_q.rx_auto_off;
  assign rx_mute = s_q.rx_mute;

  default clocking @(posedge mclk);
  endclocking
  default disable iff (!rstn);

  a_tx_off_wins: // [R7]
  assert property (s_q.armed |-> (($past(s_q.tx_off) & tx_mute) == '0))
    else $error("Tx squelch active on a disabled lane");

  a_tx_force_mute: // [R9]
  assert property ((wr_stb && s_q.offset == OFF_TX_FORCE) |=> ##1
                   ((($past(s_q.shift, 2) & ~tx_output_off) & ~tx_mute) == '0))
    else $error("Forced Tx squelch did not reach the lane");

  a_tx_auto_mute: // [R8]
  assert property (s_q.armed |->
                   (($past(~s_q.tx_auto_off & ~s_q.tx_off & ~tx_signal_valid) & ~tx_mute)
                    == '0))
    else $error("Automatic Tx squelch missing");

  a_rx_auto_mute: // [R2] [R3]
  assert property (s_q.armed |->
                   rx_mute == $past(~s_q.rx_auto_off & ~(rx_signal_valid & rx_path_ready)))
    else $error("Rx squelch does not follow the controller");

  a_rx_mute_cause: // [R1] [R4]
  assert property ((rx_mute & $past(rx_signal_valid & rx_path_ready)) == '0)
    else $error("Rx squelched without a missing input");

  a_pol_write_lands: // [R6]
  assert property ((wr_stb && s_q.offset == OFF_TX_POL) |=>
                   tx_input_polarity_invert == $past(s_q.shift))
    else $error("Tx polarity write lost");

  a_rx_ctrl_write: // [R12] [R14] [R15]
  assert property ((wr_stb && s_q.offset == OFF_RX_OFF) |=>
                   rx_output_off == $past(s_q.shift) && $stable(rx_output_polarity_invert)
                   && $stable(rx_auto_mute_off))
    else $error("Rx disable write lost or spilled");

  a_rsvd_no_effect: // [R16]
  assert property ((wr_stb && s_q.offset == OFF_RSVD) |=>
                   $stable({s_q.tx_pol, s_q.tx_off, s_q.tx_auto_off, s_q.tx_force,
                            s_q.tx_hold, s_q.rx_pol, s_q.rx_off, s_q.rx_auto_off})
                   && tx_eq_save_buf1 == '0 && tx_eq_save_buf2 == '0)
    else $error("Reserved byte write had an effect");

  a_save_one_shot: // [R11] [R17]
  assert property ((wr_stb && s_q.offset == OFF_TX_SAVE_LO && s_q.shift[1:0] == EQ_SAVE_BUF1)
                   |=> tx_eq_save_buf1[0] && !tx_eq_save_buf2[0] ##1 !tx_eq_save_buf1[0])
    else $error("Equalizer store pulse wrong");

  a_save_exclusive: // [R11]
  assert property ((tx_eq_save_buf1 & tx_eq_save_buf2) == '0)
    else $error("Both recall buffers selected at once");

  c_forced_mute: cover property ((wr_stb && s_q.offset == OFF_TX_FORCE) ##2 (|tx_mute));
  c_eq_save: cover property (|tx_eq_save_buf2);
  c_read_byte: cover property (s_q.st == S_RDATA ##[1:600] s_q.st == S_RACK);
  c_rx_unmute: cover property ($fell(rx_mute[0]));
endmodule

// [shared/lane_ctrl_pkg.sv]
// Constants for the per-lane direct control register bank
// Summary of operation
// [R1] Rx muting only by internal squelch controller
// [R2] Rx squelched until inputs and resources ready
// [R3] Host enables auto Rx squelch per lane
// [R4] No host-forced squelch for Rx outputs
// [R5] Host keeps auto-squelch settings uniform per path
// [R6] Tx input polarity byte, one bit per lane
// [R7] Tx output disable byte, bit set disables
// [R8] Tx auto squelch byte, bit set disables controller
// [R9] Tx forced squelch byte, bit set squelches output
// [R10] Tx equalizer freeze byte holds adaptation
// [R11] Two-bit store codes select recall buffer
// [R12] Rx output polarity flip per lane
// [R13] Host disables Rx outputs per lane
// [R14] Rx output disable byte, bit set disables
// [R15] Rx auto squelch byte, bit set disables
// [R16] Reserved byte reads zero, ignores writes
// [R17] Store write is one-shot; readback unspecified
package lane_ctrl_pkg;
  localparam int LANES = 8;
  localparam int SAVE_LANES = 4;
  // Arbitrary bus address; set per board
  localparam logic [6:0] DEV_ADDR = 7'h2A;
  localparam logic [7:0] OFF_TX_POL = 8'h81;
  localparam logic [7:0] OFF_TX_OFF = 8'h82;
  localparam logic [7:0] OFF_TX_AUTO = 8'h83;
  localparam logic [7:0] OFF_TX_FORCE = 8'h84;
  localparam logic [7:0] OFF_RSVD = 8'h85;
  localparam logic [7:0] OFF_TX_HOLD = 8'h86;
  localparam logic [7:0] OFF_TX_SAVE_LO = 8'h87;
  localparam logic [7:0] OFF_TX_SAVE_HI = 8'h88;
  localparam logic [7:0] OFF_RX_POL = 8'h89;
  localparam logic [7:0] OFF_RX_OFF = 8'h8A;
  localparam logic [7:0] OFF_RX_AUTO = 8'h8B;
  localparam logic [7:0] RST_CTRL = 8'h00;
  localparam logic [7:0] RD_NONE = 8'h00;
  localparam logic [1:0] EQ_SAVE_BUF1 = 2'h1;
  localparam logic [1:0] EQ_SAVE_BUF2 = 2'h2;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [3:0] LAST_BIT = 4'h7;
  localparam logic RW_READ = 1'h1;
endpackage

// [rtl/twi_edges.sv]
// Two-wire pin synchroniser and bus condition detector
`timescale 1ns/1ns
module twi_edges (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic scl_rise,
  output logic scl_fall,
  output logic start_seen,
  output logic stop_seen,
  output logic sda_level
);
  import lane_ctrl_pkg::*;

  typedef struct packed {
    logic [1:0] scl_sync;
    logic [1:0] sda_sync;
    logic scl_prev;
    logic sda_prev;
  } sync_t;

  sync_t q_q;
  sync_t q_d;

  // Only the second stage and its delayed copy feed any logic
  always_comb
  begin
    q_d = q_q;
    q_d.scl_sync = {q_q.scl_sync[0], scl_in};
    q_d.sda_sync = {q_q.sda_sync[0], sda_in};
    q_d.scl_prev = q_q.scl_sync[1];
    q_d.sda_prev = q_q.sda_sync[1];
  end

  // Idle bus is high; resetting to ones avoids a false start
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      q_q <= '1;
    else
      q_q <= q_d;
  end

  assign scl_rise = q_q.scl_sync[1] & ~q_q.scl_prev;
  assign scl_fall = ~q_q.scl_sync[1] & q_q.scl_prev;
  assign start_seen = q_q.scl_sync[1] & q_q.scl_prev & q_q.sda_prev & ~q_q.sda_sync[1];
  assign stop_seen = q_q.scl_sync[1] & q_q.scl_prev & ~q_q.sda_prev & q_q.sda_sync[1];
  assign sda_level = q_q.sda_sync[1];
endmodule

// [test/twi_host_model.sv]
// Behavioural two-wire host master for the management port
`timescale 1ns/1ns
module twi_host_model (
  input wire logic mclk,
  input wire logic sda_line,
  output logic scl_drv,
  output logic sda_drv
);
  // Phases well above the 3-cycle minimum the port needs
  localparam int HALF = 10;
  initial
  begin
    scl_drv = 1'b1;
    sda_drv = 1'b1;
  end
  task automatic hold(input int n);
    repeat (n) @(negedge mclk);
  endtask
  // Also serves as repeated start from a low clock
  task automatic start_cond();
    hold(2);
    sda_drv = 1'b1;
    hold(2);
    scl_drv = 1'b1;
    hold(HALF);
    sda_drv = 1'b0;
    hold(HALF);
    scl_drv = 1'b0;
  endtask
  task automatic stop_cond();
    hold(2);
    sda_drv = 1'b0;
    hold(HALF);
    scl_drv = 1'b1;
    hold(HALF);
    sda_drv = 1'b1;
    hold(HALF);
  endtask
  // Ninth slot carries ack_drv; data only moves while the clock is low
  task automatic xfer(input logic [7:0] tx, input logic ack_drv, output logic [7:0] rx,
    output logic got_ack);
    logic [8:0] bits;
    bits = {tx, ack_drv};
    for (int i = 8; i >= 0; i--)
    begin
      hold(2);
      sda_drv = bits[i];
      hold(HALF - 2);
      scl_drv = 1'b1;
      hold(HALF);
      if (i > 0)
        rx[i-1] = sda_line;
      else
        got_ack = ~sda_line;
      scl_drv = 1'b0;
    end
  endtask
endmodule

// [test/testbench.sv]
// Self-checking bench for the lane control register bank
`timescale 1ns/1ns
module testbench;
  import lane_ctrl_pkg::*;
  localparam logic [7:0] OFFS [11] = '{8'h80, 8'h81, 8'h82, 8'h83, 8'h84, 8'h85,
    8'h86, 8'h89, 8'h8A, 8'h8B, 8'h8C};
  logic mclk, rstn, scl_drv, sda_drv, sda_line, sda_out, sda_oe_n, ack;
  logic [LANES-1:0] tx_valid, rx_valid, rx_ready, tx_pol, tx_off, tx_auto, tx_force;
  logic [LANES-1:0] tx_hold, buf1, buf2, tx_mute, rx_pol, rx_off, rx_auto, rx_mute;
  logic [LANES-1:0] seen1, seen2;
  logic seen_clr;
  logic [7:0] shadow [8'h80:8'h8C];
  logic [7:0] q, r;
  int err_total = 0;
  int comparisons = 0;
  // Open drain with pull-up: low if either party pulls
  assign sda_line = sda_drv & (sda_oe_n | sda_out);
  twi_host_model u_host (.mclk(mclk), .sda_line(sda_line), .scl_drv(scl_drv),
    .sda_drv(sda_drv));
  lane_ctrl_regs u_dut (.mclk(mclk), .rstn(rstn), .scl_in(scl_drv), .sda_in(sda_line),
    .sda_out(sda_out), .sda_oe_n(sda_oe_n), .tx_signal_valid(tx_valid),
    .rx_signal_valid(rx_valid), .rx_path_ready(rx_ready), .tx_input_polarity_invert(tx_pol),
    .tx_output_off(tx_off), .tx_auto_mute_off(tx_auto), .tx_forced_mute(tx_force),
    .tx_equalizer_hold(tx_hold), .tx_eq_save_buf1(buf1), .tx_eq_save_buf2(buf2),
    .tx_mute(tx_mute), .rx_output_polarity_invert(rx_pol), .rx_output_off(rx_off),
    .rx_auto_mute_off(rx_auto), .rx_mute(rx_mute));
  initial
  begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  // Sampled away from the launching edge so a one-cycle pulse is caught once
  always @(negedge mclk)
  begin
    seen1 <= seen_clr ? '0 : (seen1 | buf1);
    seen2 <= seen_clr ? '0 : (seen2 | buf2);
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      err_total++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic send(input logic [7:0] b);
    u_host.xfer(b, 1'b1, q, ack);
    check(ack, 1'b1);
  endtask
  task automatic write_reg(input logic [7:0] off, input logic [7:0] d);
    u_host.start_cond();
    send({DEV_ADDR, 1'b0});
    send(off);
    send(d);
    u_host.stop_cond();
    if (off inside {8'h81, 8'h82, 8'h83, 8'h84, 8'h86, 8'h89, 8'h8A, 8'h8B})
      shadow[off] = d;
  endtask
  // Offset pointer set by a write, then read after repeated start, NACK ends it
  task automatic read_reg(input logic [7:0] off, output logic [7:0] d);
    u_host.start_cond();
    send({DEV_ADDR, 1'b0});
    send(off);
    u_host.start_cond();
    send({DEV_ADDR, RW_READ});
    u_host.xfer(8'hFF, 1'b1, d, ack);
    u_host.stop_cond();
  endtask
  function automatic logic [7:0] port_val(input logic [7:0] off);
    case (off)
      OFF_TX_POL: return tx_pol;
      OFF_TX_OFF: return tx_off;
      OFF_TX_AUTO: return tx_auto;
      OFF_TX_FORCE: return tx_force;
      OFF_TX_HOLD: return tx_hold;
      OFF_RX_POL: return rx_pol;
      OFF_RX_OFF: return rx_off;
      OFF_RX_AUTO: return rx_auto;
      default: return 8'h00;
    endcase
  endfunction
  function automatic logic [3:0] save_mask(input logic [7:0] w, input logic [1:0] c);
    for (int i = 0; i < SAVE_LANES; i++)
      save_mask[i] = (w[2*i+:2] == c);
  endfunction
  task automatic report_and_stop();
    $display("comparisons %0d err_total %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial
  begin
    #3_600_000;
    err_total++;
    report_and_stop();
  end
  initial
  begin
    void'($urandom(32'h9453));
    rstn = 1'b0;
    {tx_valid, rx_valid, rx_ready} = '0;
    seen_clr = 1'b1;
    for (int a = 8'h80; a <= 8'h8C; a++)
      shadow[a] = 8'h00;
    repeat (4) @(negedge mclk);
    rstn = 1'b1;
    seen_clr <= 1'b0;
    repeat (4) @(negedge mclk);
    foreach (OFFS[i])
    begin
      read_reg(OFFS[i], q);
      check(q, 8'h00);
      check(port_val(OFFS[i]), 8'h00);
    end
    // First pass all ones, then random bytes; reserved and unmapped must not stick
    for (int p = 0; p < 2; p++)
      foreach (OFFS[i])
      begin
        write_reg(OFFS[i], (p == 0) ? 8'hFF : 8'($urandom));
        check(port_val(OFFS[i]), shadow[OFFS[i]]);
        read_reg(OFFS[i], q);
        check(q, shadow[OFFS[i]]);
      end
    // Store codes: every code on the low lanes, random on the high lanes
    r = 8'($urandom);
    seen_clr <= 1'b1;
    @(negedge mclk);
    seen_clr <= 1'b0;
    write_reg(OFF_TX_SAVE_LO, 8'h39);
    write_reg(OFF_TX_SAVE_HI, r);
    check(seen1, {save_mask(r, EQ_SAVE_BUF1), save_mask(8'h39, EQ_SAVE_BUF1)});
    check(seen2, {save_mask(r, EQ_SAVE_BUF2), save_mask(8'h39, EQ_SAVE_BUF2)});
    // Burst: two data bytes, then a two-byte read with host ACK; offset steps by one
    r = 8'($urandom);
    u_host.start_cond();
    send({DEV_ADDR, 1'b0});
    send(OFF_RX_POL);
    send(r);
    send(~r);
    u_host.stop_cond();
    shadow[OFF_RX_POL] = r;
    shadow[OFF_RX_OFF] = ~r;
    check(rx_pol, r);
    check(rx_off, ~r);
    u_host.start_cond();
    send({DEV_ADDR, 1'b0});
    send(OFF_RX_POL);
    u_host.start_cond();
    send({DEV_ADDR, RW_READ});
    u_host.xfer(8'hFF, 1'b0, q, ack);
    check(q, r);
    u_host.xfer(8'hFF, 1'b1, q, ack);
    check(q, ~r);
    u_host.stop_cond();
    for (int k = 0; k < 6; k++)
    begin
      write_reg(OFF_TX_OFF, 8'($urandom));
      write_reg(OFF_TX_AUTO, 8'($urandom));
      write_reg(OFF_TX_FORCE, 8'($urandom));
      r = 8'($urandom);
      write_reg(OFF_RX_AUTO, {{4{r[1]}}, {4{r[0]}}});
      for (int j = 0; j < 4; j++)
      begin
        @(negedge mclk);
        tx_valid = (j < 2) ? {8{j[0]}} : 8'($urandom);
        rx_valid = (j < 2) ? {8{j[0]}} : 8'($urandom);
        rx_ready = (j < 2) ? 8'hFF : 8'($urandom);
        repeat (2) @(negedge mclk);
        check(tx_mute, ~shadow[OFF_TX_OFF] & (shadow[OFF_TX_FORCE] |
          (~shadow[OFF_TX_AUTO] & ~tx_valid)));
        check(rx_mute, ~shadow[OFF_RX_AUTO] & ~(rx_valid & rx_ready));
      end
    end
    u_host.start_cond();
    u_host.xfer({DEV_ADDR ^ 7'h01, 1'b0}, 1'b1, q, ack);
    u_host.stop_cond();
    check(ack, 1'b0);
    report_and_stop();
  end
endmodule
